// [verilog/umc_defines.svh]
`ifndef UMC_DEFINES_SVH
`define UMC_DEFINES_SVH
// ==========================================================
// register byte offsets
`define UMC_OFF_CTRL    8'h00
`define UMC_OFF_ASTAT   8'h04
`define UMC_OFF_REQ     8'h08
`define UMC_OFF_M4TX    8'h0c
`define UMC_OFF_M4RX    8'h10
`define UMC_OFF_M56TX   8'h14
`define UMC_OFF_M56RX   8'h18
`define UMC_OFF_FEBE    8'h1c
`define UMC_OFF_NEBE    8'h20
`define UMC_OFF_EOC     8'h24
`define UMC_OFF_MODE    8'h28
`define UMC_OFF_ISTAT   8'h2c
`define UMC_OFF_IMASK   8'h30
// ==========================================================
// field positions
`define UMC_CTRL_SWRST  3
`define UMC_ST_LINKUP   3
`define UMC_ST_ERR      2
`define UMC_ST_SFS      1
`define UMC_ST_AIP      0
`define UMC_REQ_ACT     2
`define UMC_REQ_CE      0
`define UMC_MODE_AUTO   0
`define UMC_MODE_TRI    1
`define UMC_IRQ_ACT     0
`define UMC_IRQ_M4      1
`define UMC_IRQ_EOC     2
// ==========================================================
// reset values and codes
`define UMC_RST_BYTE    8'hff
`define UMC_RST_EOC     9'h1ff
`define UMC_EOC_RTN     9'h1ff
`define UMC_EOC_LOOP2   9'h150
`define UMC_CNT_DUAL    2'h2
`define UMC_CNT_TRI     2'h3
`define UMC_CNT_MAX     8'hff
`endif

// [verilog/umc_pkg.sv]
package umc_pkg;
    // ==========================================================
    // line side, from the transceiver core on clk_i
    typedef struct packed {
        logic       frame;      // one-cycle pulse per received frame
        logic [7:0] m4;         // raw received m4 bits, act at 7
        logic [7:0] m56;        // raw received m5/m6 bits
        logic [8:0] eoc;        // raw received eoc message
        logic       febe_err;   // far-end block error pulse
        logic       nebe_err;   // near-end block error pulse
        logic       wakeup;     // wakeup tone detected
        logic       superframe_sync_flag;        // superframe sync held
        logic       linkup;     // link established
        logic       err_ind;    // error indication level
        logic       deact_done; // deactivation confirmed
    } umc_line_rx_type;
    // ==========================================================
    // line side, toward the transceiver core
    typedef struct packed {
        logic [7:0] m4;
        logic [7:0] m56;
        logic [8:0] eoc;
        logic       transparent;
        logic       warm_start;
        logic       loopback;
        logic       act_req;
    } umc_line_tx_type;
    // ==========================================================
    // activation states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ACTING   = 7'h02,
        ST_SYNCED   = 7'h04,
        ST_LINKED   = 7'h08,
        ST_SYNC_LEVEL3_TRANSPARENT_STATE     = 7'h10,
        ST_NORMAL   = 7'h20,
        ST_TEARDOWN = 7'h40
    } umc_state_type;
endpackage

// [verilog/umc_consec_check.sv]
`timescale 1ns/1ps
`include "umc_defines.svh"
// ==========================================================
// consecutive-equal checker: a value counts once it was
// received need_i frames in a row
module umc_consec_check #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         frame_i,
    input  wire logic [W-1:0] data_i,
    input  wire logic [1:0]   need_i,
    output logic      [W-1:0] data_o,
    output logic              upd_o
);
    logic [W-1:0] cand_r; // last received value
    logic [1:0]   cnt_r;  // frames in a row with cand_r
    logic [1:0]   cnt_nxt;
    logic         same;
    logic         hit;

    // saturating count, restart on a differing frame
    assign same    = (data_i == cand_r);
    assign cnt_nxt = !same ? 2'h1 : (cnt_r == 2'h3) ? 2'h3 : 2'(cnt_r + 2'h1);
    assign hit     = frame_i && (cnt_nxt >= need_i) && (data_i != data_o);

    // ==========================================================
    // candidate tracking and validated output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cand_r <= '1;
            cnt_r  <= 2'h0;
            data_o <= '1;
            upd_o  <= 1'b0;
        end else begin
            upd_o <= hit;
            if (frame_i) begin
                cand_r <= data_i;
                cnt_r  <= cnt_nxt;
            end
            if (hit) begin
                data_o <= data_i;
            end
        end
    end

    // with need_i above 1, a lone differing frame never validates
    AST_LONE_FRAME: assert property (@(posedge clk_i) disable iff (rst_i)
        (frame_i && !same && need_i > 2'h1) |=> !upd_o)
        else $error("value validated after a single frame");
endmodule

// [verilog/umc_maint_ctrl.sv]
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "umc_defines.svh"
module umc_maint_ctrl
    import umc_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            cyc_i,
    input  wire logic            stb_i,
    input  wire logic            we_i,
    input  wire logic [7:0]      adr_i,
    input  wire logic [3:0]      sel_i,
    input  wire logic [31:0]     dat_i,
    output logic      [31:0]     dat_o,
    output logic                 ack_o,
    input  wire umc_line_rx_type line_rx_i,
    output umc_line_tx_type      line_tx_o,
    output logic                 irq_o
);
    // ==========================================================
    // software registers
    logic [3:0]    ctrl_r;   // control nibble
    logic [3:0]    req_r;    // request nibble
    logic [7:0]    m4tx_r;   // m4 transmit byte
    logic [7:0]    m56tx_r;  // m5/m6 transmit byte
    logic [8:0]    eoc_r;    // embedded operations, software side
    logic [1:0]    mode_r;   // eoc auto, m4 trinal
    logic [2:0]    imask_r;  // interrupt mask
    // ==========================================================
    // block state
    logic [2:0]    istat_r;  // sticky interrupt status
    logic [3:0]    astat_r;  // activation status nibble
    logic [7:0]    febe_r;   // far-end error count
    logic [7:0]    nebe_r;   // near-end error count
    logic          warm_r;   // warm start enabled
    logic          loop_r;   // eoc loopback active
    logic [8:0]    eoc_ack_r; // echoed message in auto mode
    umc_state_type state_r;
    umc_state_type state_nxt;
    // ==========================================================
    // bus decode
    logic       req_take; // request taken this edge
    logic       wr_en;
    logic       lane0;
    logic       lane1;
    logic       int_rst;  // power-up or software reset
    logic       hit_ctrl, hit_req, hit_m4tx, hit_m56tx, hit_febe;
    logic       hit_nebe, hit_eoc, hit_mode, hit_istat, hit_imask;
    logic [31:0] rd_data;
    assign req_take  = cyc_i && stb_i && !ack_o;
    assign wr_en     = req_take && we_i;
    assign lane0     = sel_i[0];
    assign lane1     = sel_i[1];
    assign int_rst   = rst_i || ctrl_r[`UMC_CTRL_SWRST];
    assign hit_ctrl  = (adr_i == `UMC_OFF_CTRL);
    assign hit_req   = (adr_i == `UMC_OFF_REQ);
    assign hit_m4tx  = (adr_i == `UMC_OFF_M4TX);
    assign hit_m56tx = (adr_i == `UMC_OFF_M56TX);
    assign hit_febe  = (adr_i == `UMC_OFF_FEBE);
    assign hit_nebe  = (adr_i == `UMC_OFF_NEBE);
    assign hit_eoc   = (adr_i == `UMC_OFF_EOC);
    assign hit_mode  = (adr_i == `UMC_OFF_MODE);
    assign hit_istat = (adr_i == `UMC_OFF_ISTAT);
    assign hit_imask = (adr_i == `UMC_OFF_IMASK);
    // ==========================================================
    // received maintenance channels
    logic [2:0] m4_tri_val;  // act, dea, uoa
    logic [4:0] m4_dual_val; // remaining m4 bits
    logic [8:0] eoc_val;
    logic       tri_upd, dual_upd, eoc_upd;
    logic [7:0] m56rx_r;
    logic [1:0] tri_need;
    logic [7:0] m4_rx;
    // only act, dea, uoa may be trinal checked
    assign tri_need = mode_r[`UMC_MODE_TRI] ? `UMC_CNT_TRI : `UMC_CNT_DUAL;
    assign m4_rx    = {m4_tri_val, m4_dual_val};
    umc_consec_check #(.W(3)) u_m4_tri (
        .clk_i  (clk_i),
        .rst_i  (int_rst),
        .frame_i(line_rx_i.frame),
        .data_i (line_rx_i.m4[7:5]),
        .need_i (tri_need),
        .data_o (m4_tri_val),
        .upd_o  (tri_upd)
    );
    umc_consec_check #(.W(5)) u_m4_dual (
        .clk_i  (clk_i),
        .rst_i  (int_rst),
        .frame_i(line_rx_i.frame),
        .data_i (line_rx_i.m4[4:0]),
        .need_i (`UMC_CNT_DUAL),
        .data_o (m4_dual_val),
        .upd_o  (dual_upd)
    );
    // eoc is always trinal checked before use
    umc_consec_check #(.W(9)) u_eoc (
        .clk_i  (clk_i),
        .rst_i  (int_rst),
        .frame_i(line_rx_i.frame),
        .data_i (line_rx_i.eoc),
        .need_i (`UMC_CNT_TRI),
        .data_o (eoc_val),
        .upd_o  (eoc_upd)
    );
    // ==========================================================
    // activation state machine
    logic rx_act;      // validated far-end act
    logic rx_dea_req;  // far end intends to deactivate (dea low)
    logic warm_en_st;  // current state enables warm start
    logic in_link;
    assign rx_act     = m4_tri_val[2];
    assign rx_dea_req = !m4_tri_val[1];
    assign warm_en_st = state_r[2] | state_r[3] | state_r[4] | state_r[5];
    assign in_link    = warm_en_st;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (req_r[`UMC_REQ_ACT] || line_rx_i.wakeup) begin
                    state_nxt = ST_ACTING;
                end
            end
            ST_ACTING: begin
                if (line_rx_i.superframe_sync_flag) begin
                    state_nxt = ST_SYNCED;
                end
            end
            ST_SYNCED: begin
                if (line_rx_i.linkup) begin
                    state_nxt = ST_LINKED;
                end
            end
            ST_LINKED: begin
                if (rx_act) begin
                    state_nxt = ST_SYNC_LEVEL3_TRANSPARENT_STATE;
                end
            end
            ST_SYNC_LEVEL3_TRANSPARENT_STATE: begin
                if (req_r[`UMC_REQ_CE]) begin
                    state_nxt = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                if (!req_r[`UMC_REQ_CE]) begin
                    state_nxt = ST_SYNC_LEVEL3_TRANSPARENT_STATE;
                end
            end
            ST_TEARDOWN: begin
                if (line_rx_i.deact_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // deactivation and sync loss override the above
        if (in_link && rx_dea_req) begin
            state_nxt = ST_TEARDOWN;
        end else if (in_link && !line_rx_i.superframe_sync_flag) begin
            state_nxt = ST_ACTING;
        end
    end

    // ==========================================================
    // state, warm start and status nibble
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            state_r <= ST_IDLE;
            warm_r  <= 1'b0;
            astat_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            // any transition except enabling state to teardown clears it
            if (state_nxt != state_r) begin
                warm_r <= warm_en_st && (state_nxt == ST_TEARDOWN);
            end
            astat_r[`UMC_ST_LINKUP] <= state_r[3] | state_r[4] | state_r[5];
            astat_r[`UMC_ST_ERR]    <= line_rx_i.err_ind;
            astat_r[`UMC_ST_SFS]    <= warm_en_st;
            astat_r[`UMC_ST_AIP]    <= state_r[1] | state_r[2] | state_r[3];
        end
    end
    // ==========================================================
    // software writable registers, reset by power-up only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r  <= 4'h0;
            req_r   <= 4'h0;
            m4tx_r  <= `UMC_RST_BYTE;
            m56tx_r <= `UMC_RST_BYTE;
            eoc_r   <= `UMC_RST_EOC;
            mode_r  <= 2'h0;
            imask_r <= 3'h0;
        end else if (wr_en) begin
            if (lane0 && hit_ctrl)  ctrl_r  <= dat_i[3:0];
            if (lane0 && hit_req)   req_r   <= dat_i[3:0];
            if (lane0 && hit_m4tx)  m4tx_r  <= dat_i[7:0];
            if (lane0 && hit_m56tx) m56tx_r <= dat_i[7:0];
            if (lane0 && hit_mode)  mode_r  <= dat_i[1:0];
            if (lane0 && hit_imask) imask_r <= dat_i[2:0];
            if (hit_eoc && lane0)   eoc_r[7:0] <= dat_i[7:0];
            if (hit_eoc && lane1)   eoc_r[8]   <= dat_i[8];
        end
    end
    // ==========================================================
    // block error counters: no sync gating, so counts survive
    // a temporary loss of sync; a write loads the value
    logic febe_wr, nebe_wr;
    assign febe_wr = wr_en && lane0 && hit_febe;
    assign nebe_wr = wr_en && lane0 && hit_nebe;
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            febe_r <= 8'h00;
            nebe_r <= 8'h00;
        end else begin
            if (febe_wr) begin
                febe_r <= dat_i[7:0];
            end else if (line_rx_i.febe_err && febe_r != `UMC_CNT_MAX) begin
                febe_r <= 8'(febe_r + 8'h01);
            end
            if (nebe_wr) begin
                nebe_r <= dat_i[7:0];
            end else if (line_rx_i.nebe_err && nebe_r != `UMC_CNT_MAX) begin
                nebe_r <= 8'(nebe_r + 8'h01);
            end
        end
    end
    // ==========================================================
    // received m5/m6 taken every frame, and automatic eoc
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            m56rx_r   <= `UMC_RST_BYTE;
            loop_r    <= 1'b0;
            eoc_ack_r <= `UMC_RST_EOC;
        end else begin
            if (line_rx_i.frame) begin
                m56rx_r <= line_rx_i.m56;
            end
            // auto mode: executes and acknowledges checked messages
            if (eoc_upd && mode_r[`UMC_MODE_AUTO]) begin
                eoc_ack_r <= eoc_val;
                if (eoc_val == `UMC_EOC_LOOP2) begin
                    loop_r <= 1'b1;
                end else if (eoc_val == `UMC_EOC_RTN) begin
                    loop_r <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // interrupts: set wins over a write-one clear
    logic [2:0] ev;
    logic [2:0] istat_clr;
    logic [2:0] istat_nxt;
    assign ev[`UMC_IRQ_ACT] = (state_nxt != state_r);
    assign ev[`UMC_IRQ_M4]  = tri_upd || dual_upd;
    assign ev[`UMC_IRQ_EOC] = eoc_upd;
    assign istat_clr = (wr_en && lane0 && hit_istat) ? dat_i[2:0] : 3'h0;
    assign istat_nxt = (istat_r & ~istat_clr) | ev;
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            istat_r <= 3'h0;
            irq_o   <= 1'b0;
        end else begin
            istat_r <= istat_nxt;
            irq_o   <= |(istat_nxt & imask_r);
        end
    end

    // ==========================================================
    // read mux; unmapped offsets read zero but still ack
    assign rd_data =
        hit_ctrl  ? {28'h0, ctrl_r} :
        (adr_i == `UMC_OFF_ASTAT) ? {28'h0, astat_r} :
        hit_req   ? {28'h0, req_r} :
        hit_m4tx  ? {24'h0, m4tx_r} :
        (adr_i == `UMC_OFF_M4RX)  ? {24'h0, m4_rx} :
        hit_m56tx ? {24'h0, m56tx_r} :
        (adr_i == `UMC_OFF_M56RX) ? {24'h0, m56rx_r} :
        hit_febe  ? {24'h0, febe_r} :
        hit_nebe  ? {24'h0, nebe_r} :
        hit_eoc   ? {23'h0, eoc_val} :
        hit_mode  ? {30'h0, mode_r} :
        hit_istat ? {29'h0, istat_r} :
        hit_imask ? {29'h0, imask_r} : 32'h0;
    // single-wait-state slave: ack one cycle after the take
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req_take;
            if (req_take) begin
                dat_o <= rd_data;
            end
        end
    end

    // ==========================================================
    // line transmit side, all registered
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            line_tx_o <= '0;
        end else begin
            // state changes never rewrite m4: it mirrors software
            line_tx_o.m4          <= m4tx_r;
            line_tx_o.m56         <= m56tx_r;
            line_tx_o.eoc         <= mode_r[`UMC_MODE_AUTO] ? eoc_ack_r : eoc_r;
            line_tx_o.transparent <= state_r[4] | state_r[5];
            line_tx_o.warm_start  <= warm_r;
            line_tx_o.loopback    <= loop_r;
            line_tx_o.act_req     <= req_r[`UMC_REQ_ACT];
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (int_rst);
    sequence s_m4_write;
        wr_en && lane0 && hit_m4tx;
    endsequence
    sequence s_enter_td_warm;
        warm_en_st && state_nxt == ST_TEARDOWN;
    endsequence

    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack held two cycles");
    AST_ACK_TAKE: assert property (req_take |=> ack_o && dat_o == $past(rd_data))
        else $error("request not answered next cycle");
    AST_LINKUP_BIT: assert property (state_r == ST_NORMAL |=> astat_r[`UMC_ST_LINKUP])
        else $error("linkup status missing in normal state");
    AST_AIP_BIT: assert property (state_r == ST_IDLE |=> !astat_r[`UMC_ST_AIP])
        else $error("activation in progress shown while idle");
    AST_WARM_KEEP: assert property (s_enter_td_warm |=> ##1 line_tx_o.warm_start)
        else $error("warm start lost entering teardown");
    AST_WARM_DROP: assert property ((state_nxt != state_r && state_nxt != ST_TEARDOWN)
        |=> !warm_r)
        else $error("warm start kept on other transition");
    AST_M4_TX: assert property (s_m4_write |=> ##1 line_tx_o.m4 == $past(dat_i[7:0], 2))
        else $error("m4 transmit does not follow register");
    AST_TRANSP: assert property (state_r == ST_SYNC_LEVEL3_TRANSPARENT_STATE |=> line_tx_o.transparent)
        else $error("sync_level3_transparent_state state not transparent");
    AST_FEBE_CNT: assert property ((line_rx_i.febe_err && !febe_wr && febe_r != `UMC_CNT_MAX
        && !line_rx_i.superframe_sync_flag) |=> febe_r == 8'($past(febe_r) + 8'h01))
        else $error("far-end count lost during sync loss");
    AST_EOC_ECHO: assert property ((eoc_upd && mode_r[`UMC_MODE_AUTO]) |=> ##1
        line_tx_o.eoc == $past(eoc_val, 2))
        else $error("auto eoc not acknowledged");
    AST_IRQ_SET: assert property ((ev[`UMC_IRQ_EOC] && imask_r[`UMC_IRQ_EOC]) |=> irq_o)
        else $error("unmasked event did not raise irq");
endmodule

// [verification/umc_line_model.sv]
`timescale 1ns/1ps
// ==========================================================
// far transceiver: frames and block error pulses
module umc_line_model
    import umc_pkg::*;
(
    input  wire logic       clk_i,
    output umc_line_rx_type line_rx_o
);
    // levels are written by the bench, pulses and frames here
    initial line_rx_o = '0;
    // ==========================================================
    // frames a few cycles apart; data inverted in between so a
    // checker sampling off the frame pulse picks up junk
    task automatic send(input logic [7:0] m4, input logic [7:0] m56, input logic [8:0] eoc, input int n);
        repeat (n) begin
            @(posedge clk_i);
            line_rx_o.frame <= 1'b1;
            {line_rx_o.m4, line_rx_o.m56, line_rx_o.eoc} <= {m4, m56, eoc};
            @(posedge clk_i);
            line_rx_o.frame <= 1'b0;
            {line_rx_o.m4, line_rx_o.m56, line_rx_o.eoc} <= ~{m4, m56, eoc};
            repeat (3) @(posedge clk_i);
        end
    endtask
    // one-cycle error pulses on both counters together
    task automatic errs(input int n);
        repeat (n) begin
            @(posedge clk_i);
            {line_rx_o.febe_err, line_rx_o.nebe_err} <= 2'b11;
            @(posedge clk_i);
            {line_rx_o.febe_err, line_rx_o.nebe_err} <= 2'b00;
        end
    endtask
endmodule

// [verification/test_umc_maint_ctrl.sv]
`timescale 1ns/1ps
`include "umc_defines.svh"
// ==========================================================
// bench: wishbone register calls, line side from the model
module test_umc_maint_ctrl
    import umc_pkg::*;
;
    logic            clk_i;
    logic            rst_i;
    logic            cyc_i;
    logic            stb_i;
    logic            we_i;
    logic [7:0]      adr_i;
    logic [3:0]      sel_i;
    logic [31:0]     dat_i;
    logic [31:0]     dat_o;
    logic            ack_o;
    logic            irq_o;
    umc_line_rx_type line_rx;
    umc_line_tx_type line_tx_o;
    int              errors;
    int              checks;

    umc_maint_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .line_rx_i(line_rx), .line_tx_o(line_tx_o), .irq_o(irq_o));
    umc_line_model line (.clk_i(clk_i), .line_rx_o(line_rx));

    // 40 MHz
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // ==========================================================
    // helpers
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // classic cycle: hold until ack is seen, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'h3, d};
        // no cycle limit here: only the watchdog may end a wait
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // run takes under 2000 cycles
    initial begin
        wt(20000);
        errors++;
        give_verdict;
    end
    // ==========================================================
    // main sequence
    initial begin
        errors = 0;
        checks = 0;
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
        wt(20);
        rst_i <= 1'b0;
        wt(2);
        chk({3'h0, line_tx_o}, {3'h0, 8'hff, 8'hff, 9'h1ff, 4'h0});
        rd(`UMC_OFF_M4TX, 32'hff);
        rd(8'h3c, 32'h0);
        // transmit channels reach the line
        wr(`UMC_OFF_M4TX, 32'h77);
        wr(`UMC_OFF_M56TX, 32'h5a);
        wt(2);
        chk({24'h0, line_tx_o.m4}, 32'h77);
        chk({24'h0, line_tx_o.m56}, 32'h5a);
        wr(`UMC_OFF_M56TX, 32'hff);
        // receive side, dual check on m4, three frames for eoc
        line.send(8'h7f, 8'ha5, 9'h0ab, 3);
        wt(2);
        rd(`UMC_OFF_M4RX, 32'h7f);
        rd(`UMC_OFF_M56RX, 32'ha5);
        rd(`UMC_OFF_EOC, 32'h0ab);
        wr(`UMC_OFF_EOC, 32'h1cc);
        wt(3);
        chk({23'h0, line_tx_o.eoc}, 32'h1cc);
        wr(`UMC_OFF_EOC, 32'h1ff);
        wt(3);
        chk({23'h0, line_tx_o.eoc}, 32'h1ff);
        // trinal check covers only bits 7:5
        wr(`UMC_OFF_MODE, 32'h2);
        line.send(8'hf0, 8'hff, 9'h0ab, 2);
        wt(2);
        rd(`UMC_OFF_M4RX, 32'h70);
        line.send(8'hf0, 8'hff, 9'h0ab, 1);
        wt(2);
        rd(`UMC_OFF_M4RX, 32'hf0);
        // interrupts: sticky, masked, cleared by ones
        rd(`UMC_OFF_ISTAT, 32'h6);
        chk({31'h0, irq_o}, 32'h0);
        wr(`UMC_OFF_IMASK, 32'h2);
        wt(2);
        chk({31'h0, irq_o}, 32'h1);
        wr(`UMC_OFF_ISTAT, 32'h2);
        wt(2);
        chk({31'h0, irq_o}, 32'h0);
        wr(`UMC_OFF_IMASK, 32'h1);
        // activation walk
        wr(`UMC_OFF_REQ, 32'h4);
        wt(3);
        rd(`UMC_OFF_ASTAT, 32'h1);
        chk({30'h0, irq_o, line_tx_o.act_req}, 32'h3);
        line.line_rx_o.superframe_sync_flag <= 1'b1;
        wt(3);
        rd(`UMC_OFF_ASTAT, 32'h3);
        line.line_rx_o.linkup <= 1'b1;
        wt(4);
        rd(`UMC_OFF_ASTAT, 32'ha);
        chk({31'h0, line_tx_o.transparent}, 32'h1);
        wr(`UMC_OFF_REQ, 32'h5);
        wt(3);
        chk({30'h0, line_tx_o.transparent, line_tx_o.warm_start}, 32'h2);
        // sync loss: counters keep counting
        line.line_rx_o.superframe_sync_flag <= 1'b0;
        line.errs(3);
        rd(`UMC_OFF_FEBE, 32'h3);
        rd(`UMC_OFF_NEBE, 32'h3);
        wr(`UMC_OFF_FEBE, 32'h0);
        rd(`UMC_OFF_FEBE, 32'h0);
        line.line_rx_o.superframe_sync_flag <= 1'b1;
        wt(5);
        // deactivate intent from far side, warm start kept
        line.send(8'hb0, 8'hff, 9'h0ab, 3);
        wt(4);
        chk({30'h0, line_tx_o.transparent, line_tx_o.warm_start}, 32'h1);
        wr(`UMC_OFF_REQ, 32'h0);
        line.line_rx_o.deact_done <= 1'b1;
        wt(4);
        chk({31'h0, line_tx_o.warm_start}, 32'h0);
        // automatic eoc: loopback code set and cleared, eoc event unmasked
        wr(`UMC_OFF_MODE, 32'h3);
        wr(`UMC_OFF_ISTAT, 32'h7);
        wr(`UMC_OFF_IMASK, 32'h4);
        wt(2);
        chk({31'h0, irq_o}, 32'h0);
        line.send(8'hb0, 8'hff, 9'h150, 3);
        wt(4);
        chk({22'h0, line_tx_o.loopback, line_tx_o.eoc}, 32'h350);
        chk({31'h0, irq_o}, 32'h1);
        line.send(8'hb0, 8'hff, 9'h1ff, 3);
        wt(4);
        chk({22'h0, line_tx_o.loopback, line_tx_o.eoc}, 32'h1ff);
        // software reset pulse keeps software registers
        wr(`UMC_OFF_CTRL, 32'h8);
        wt(2);
        chk({3'h0, line_tx_o}, 32'h0);
        wr(`UMC_OFF_CTRL, 32'h0);
        wt(3);
        chk({24'h0, line_tx_o.m4}, 32'h77);
        // far-end wakeup with error indication walks idle up to sync_level3_transparent_state
        line.line_rx_o.err_ind <= 1'b1;
        line.line_rx_o.wakeup  <= 1'b1;
        wt(8);
        rd(`UMC_OFF_ASTAT, 32'he);
        chk({31'h0, line_tx_o.transparent}, 32'h1);
        give_verdict;
    end
endmodule
